// file: verilog/mcu_timing_defs.svh
/*
 * Timing and field constants of the instruction sequencer.
 * Assumes inclusion by bare name from the verilog/ folder.
 */
`ifndef MCU_TIMING_DEFS_SVH
`define MCU_TIMING_DEFS_SVH

`define PC_RESET 16'h0000
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3
`define CLK_1 4'h1
`define CLK_2 4'h2
`define CLK_3 4'h3
`define CLK_4 4'h4
`define CLK_5 4'h5
`define CLK_8 4'h8
`define MAX_CLOCKS 4'h8
`define OPERAND_LO 7:0
`define OPERAND_HI 15:8

`endif

// file: verilog/mcu_timing_pkg.sv
/*
 * Types shared by the instruction sequencer and its timing table.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package mcu_timing_pkg;

	typedef enum logic [1:0] {CLS_PLAIN, CLS_JUMP, CLS_COND} instr_class_t;

	typedef enum logic {ST_OPCODE, ST_EXEC} seq_state_t;

	typedef struct packed {
		logic [1:0] len;
		logic [3:0] clocks;
		instr_class_t cls;
	} timing_t;

endpackage : mcu_timing_pkg

`default_nettype wire

// file: verilog/decode_if.sv
/*
 * Carrier between the sequencer and its opcode timing table.
 * Assumes the table is purely combinational.
 */
`timescale 1ns/100ps
`default_nettype none

interface decode_if;
	logic [7:0] opcode;
	mcu_timing_pkg::timing_t timing;

	modport rom (input opcode, output timing);
	modport core (output opcode, input timing);
endinterface : decode_if

`default_nettype wire

// file: verilog/opcode_timing_rom.sv
/*
 * Opcode to length, clock count and class lookup for the full
 * classic 8-bit instruction map.
 * Assumes the opcode is stable for the whole cycle it is read.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mcu_timing_defs.svh"

module opcode_timing_rom (
	decode_if.rom dec
);

	function automatic mcu_timing_pkg::timing_t ent(input logic [1:0] len, input logic [3:0] clocks,
		input mcu_timing_pkg::instr_class_t cls);
		mcu_timing_pkg::timing_t t;
		t.len = len;
		t.clocks = clocks;
		t.cls = cls;
		return t;
	endfunction : ent

	// Specific codes first: casez takes the first match
	always_comb begin
		casez (dec.opcode)
			// Absolute jump and call share the low nibble 1 on every page
			8'b????_0001: dec.timing = ent(`LEN_2, `CLK_3, mcu_timing_pkg::CLS_JUMP);
			8'h02, 8'h12: dec.timing = ent(`LEN_3, `CLK_4, mcu_timing_pkg::CLS_JUMP);
			8'h22, 8'h32: dec.timing = ent(`LEN_1, `CLK_5, mcu_timing_pkg::CLS_JUMP);
			8'h73: dec.timing = ent(`LEN_1, `CLK_3, mcu_timing_pkg::CLS_JUMP);
			8'h80: dec.timing = ent(`LEN_2, `CLK_3, mcu_timing_pkg::CLS_JUMP);
			8'h10, 8'h20, 8'h30, 8'hB4, 8'hD5, 8'b1011_1???:
				dec.timing = ent(`LEN_3, `CLK_3, mcu_timing_pkg::CLS_COND);
			8'hB5, 8'hB6, 8'hB7: dec.timing = ent(`LEN_3, `CLK_4, mcu_timing_pkg::CLS_COND);
			8'h40, 8'h50, 8'h60, 8'h70, 8'b1101_1???:
				dec.timing = ent(`LEN_2, `CLK_2, mcu_timing_pkg::CLS_COND);
			8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90:
				dec.timing = ent(`LEN_3, `CLK_3, mcu_timing_pkg::CLS_PLAIN);
			8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3:
				dec.timing = ent(`LEN_1, `CLK_3, mcu_timing_pkg::CLS_PLAIN);
			8'hA4: dec.timing = ent(`LEN_1, `CLK_4, mcu_timing_pkg::CLS_PLAIN);
			8'h84: dec.timing = ent(`LEN_1, `CLK_8, mcu_timing_pkg::CLS_PLAIN);
			8'h05, 8'h15, 8'h24, 8'h25, 8'h34, 8'h35, 8'h42, 8'h44, 8'h45, 8'h52, 8'h54, 8'h55,
			8'h62, 8'h64, 8'h65, 8'h72, 8'h74, 8'h76, 8'h77, 8'h82, 8'h86, 8'h87, 8'h92, 8'h94,
			8'h95, 8'hA0, 8'hA2, 8'hA6, 8'hA7, 8'hB0, 8'hB2, 8'hC0, 8'hC2, 8'hC5, 8'hD0, 8'hD2,
			8'hE5, 8'hF5, 8'b0111_1???, 8'b1000_1???, 8'b1010_1???:
				dec.timing = ent(`LEN_2, `CLK_2, mcu_timing_pkg::CLS_PLAIN);
			8'b????_011?: dec.timing = ent(`LEN_1, `CLK_2, mcu_timing_pkg::CLS_PLAIN);
			// Register forms, accumulator ops, carry ops and the unused code
			default: dec.timing = ent(`LEN_1, `CLK_1, mcu_timing_pkg::CLS_PLAIN);
		endcase
	end

endmodule : opcode_timing_rom

`default_nettype wire

// file: verilog/mcu_core_instruction_timing.sv
/*
 * Instruction fetch and cycle sequencer of the 8-bit core: takes at most one
 * program byte per clock, counts each instruction's clocks from its
 * opcode and retires it, redirecting the fetch on jumps and taken branches.
 * Assumes program memory answers codeAddr in the same cycle, and the
 * execute unit drives branchTaken/branchTarget on the same clock.
 */
// Function
// - Standard opcodes, modes and flag effects
// - Timing counted only in system clocks
// - Pipelined: clocks mostly equal byte count
// - Untaken conditional branch one clock shorter
// - Max eight clocks; multiply four, divide eight
// - 109 instructions with documented clock spread
// - Static design, one instruction per clock peak
// - Add forms: register 1, others 2 clocks
// - Subtract with borrow: same split as add
// - AND/OR/XOR into accumulator: same split
// - Logical to direct byte: 2 or 3
// - OR immediate to direct: three bytes, clocks
// - Carry jumps: two bytes, 2/3 clocks
// - Compare direct and jump: 4/5 clocks
// - Sixteen-bit external moves: one byte, three
`timescale 1ns/100ps
`default_nettype none
`include "mcu_timing_defs.svh"

module mcu_core_instruction_timing (
	input wire logic sys_clk,
	input wire logic rst,
	output logic [15:0] codeAddr,
	input wire logic [7:0] codeData,
	input wire logic branchTaken,
	input wire logic [15:0] branchTarget,
	output logic [7:0] execOpcode,
	output logic [15:0] execOperands,
	output logic [3:0] execCycle,
	output logic instrDone,
	output logic [7:0] doneOpcode,
	output logic [3:0] doneCycles,
	output logic doneTaken
);

	decode_if dec ();

	opcode_timing_rom u_rom (
		.dec(dec)
	);

	mcu_timing_pkg::seq_state_t stateQ;
	mcu_timing_pkg::instr_class_t clsQ;
	logic [15:0] pcQ;
	logic [7:0] opcodeQ;
	logic [15:0] operandsQ;
	logic [1:0] lenQ;
	logic [1:0] fetchIdxQ;
	logic [3:0] cntQ;
	logic [3:0] needQ;
	logic extQ;
	logic instrDoneQ;
	logic [7:0] doneOpcodeQ;
	logic [3:0] doneCyclesQ;
	logic doneTakenQ;
	logic [3:0] doneBaseQ;

	logic opStart;
	logic lastCycle;
	logic extendNow;
	logic retire;
	logic redirect;
	logic fetching;

	// In the opcode state the byte on codeData is always a new opcode
	assign opStart = stateQ == mcu_timing_pkg::ST_OPCODE;
	assign dec.opcode = codeData;

	assign lastCycle = (stateQ == mcu_timing_pkg::ST_EXEC) && (cntQ + 4'h1 == needQ);
	assign extendNow = lastCycle && clsQ == mcu_timing_pkg::CLS_COND && !extQ && branchTaken;
	assign retire = opStart ? (dec.timing.clocks == `CLK_1) : (lastCycle && !extendNow);
	assign redirect = !opStart && retire && (clsQ == mcu_timing_pkg::CLS_JUMP || extQ);
	assign fetching = (stateQ == mcu_timing_pkg::ST_EXEC) && (fetchIdxQ < lenQ);

	assign codeAddr = pcQ;
	assign execOpcode = opcodeQ;
	assign execOperands = operandsQ;
	assign execCycle = cntQ;
	assign instrDone = instrDoneQ;
	assign doneOpcode = doneOpcodeQ;
	assign doneCycles = doneCyclesQ;
	assign doneTaken = doneTakenQ;

	// Sequencer state: one opcode per clock unless more clocks are owed
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stateQ <= mcu_timing_pkg::ST_OPCODE;
		end else if (opStart) begin
			stateQ <= retire ? mcu_timing_pkg::ST_OPCODE : mcu_timing_pkg::ST_EXEC;
		end else if (retire) begin
			stateQ <= mcu_timing_pkg::ST_OPCODE;
		end
	end

	// Program counter: one step per fetched byte, or the target on a redirect; holds on extra clocks
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pcQ <= `PC_RESET;
		end else if (opStart) begin
			pcQ <= pcQ + 16'h0001;
		end else if (redirect) begin
			pcQ <= branchTarget;
		end else if (fetching) begin
			pcQ <= pcQ + 16'h0001;
		end
	end

	// Opcode and operand bytes held for the execute unit
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			opcodeQ <= 8'h00;
			operandsQ <= 16'h0000;
			lenQ <= `LEN_1;
			fetchIdxQ <= 2'h1;
			clsQ <= mcu_timing_pkg::CLS_PLAIN;
		end else if (opStart) begin
			opcodeQ <= codeData;
			operandsQ <= 16'h0000;
			lenQ <= dec.timing.len;
			fetchIdxQ <= 2'h1;
			clsQ <= dec.timing.cls;
		end else if (fetching) begin
			if (fetchIdxQ == 2'h1) begin
				operandsQ[`OPERAND_LO] <= codeData;
			end else begin
				operandsQ[`OPERAND_HI] <= codeData;
			end
			fetchIdxQ <= fetchIdxQ + 2'h1;
		end
	end

	// Clock counter; a taken branch owes exactly one more clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cntQ <= 4'h0;
			needQ <= `CLK_1;
			extQ <= 1'b0;
		end else if (opStart) begin
			cntQ <= 4'h1;
			needQ <= dec.timing.clocks;
			extQ <= 1'b0;
		end else if (stateQ == mcu_timing_pkg::ST_EXEC) begin
			cntQ <= cntQ + 4'h1;
			if (extendNow) begin
				needQ <= needQ + 4'h1;
				extQ <= 1'b1;
			end
		end
	end

	// Retirement report, one clock after the instruction's last clock
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			instrDoneQ <= 1'b0;
			doneOpcodeQ <= 8'h00;
			doneCyclesQ <= 4'h0;
			doneTakenQ <= 1'b0;
			doneBaseQ <= 4'h0;
		end else begin
			instrDoneQ <= retire;
			if (retire) begin
				doneOpcodeQ <= opStart ? codeData : opcodeQ;
				doneCyclesQ <= opStart ? `CLK_1 : cntQ + 4'h1;
				doneTakenQ <= !opStart && extQ && clsQ == mcu_timing_pkg::CLS_COND;
				doneBaseQ <= opStart ? `CLK_1 : needQ - {3'h0, extQ};
			end
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_start(logic [7:0] op);
		opStart && codeData == op;
	endsequence

	sequence s_done(logic [3:0] n, logic taken);
		instrDone && doneCycles == n && doneTaken == taken;
	endsequence

	property p_singleClock;
		opStart && dec.timing.clocks == `CLK_1 |=> instrDone && doneCycles == 4'h1;
	endproperty
	a_singleClock: assert property (p_singleClock) else $error("single clock instruction late");

	property p_condExtra;
		instrDone |-> doneCycles == doneBaseQ + {3'h0, doneTaken};
	endproperty
	a_condExtra: assert property (p_condExtra) else $error("branch clock count wrong");

	property p_maxClocks;
		stateQ == mcu_timing_pkg::ST_EXEC |-> cntQ < `MAX_CLOCKS;
	endproperty
	a_maxClocks: assert property (p_maxClocks) else $error("instruction exceeds eight clocks");

	property p_multiply;
		s_start(8'hA4) |-> ##4 s_done(4'h4, 1'b0);
	endproperty
	a_multiply: assert property (p_multiply) else $error("multiply not four clocks");

	property p_divide;
		s_start(8'h84) |-> ##8 s_done(4'h8, 1'b0);
	endproperty
	a_divide: assert property (p_divide) else $error("divide not eight clocks");

	property p_peakRate;
		opStart && dec.timing.clocks == `CLK_1 |=> opStart && codeAddr == $past(codeAddr) + 16'h0001;
	endproperty
	a_peakRate: assert property (p_peakRate) else $error("no back to back issue");

	property p_addIndirect;
		s_start(8'h26) |-> ##2 s_done(4'h2, 1'b0);
	endproperty
	a_addIndirect: assert property (p_addIndirect) else $error("add indirect not two clocks");

	property p_subtractDirect;
		s_start(8'h95) |-> ##1 !instrDone ##1 s_done(4'h2, 1'b0);
	endproperty
	a_subtractDirect: assert property (p_subtractDirect) else $error("subtract direct not two clocks");

	property p_xorReg;
		s_start(8'h6A) |=> s_done(4'h1, 1'b0) ##0 opStart;
	endproperty
	a_xorReg: assert property (p_xorReg) else $error("xor register not one clock");

	property p_andImmDirect;
		s_start(8'h53) |-> ##3 s_done(4'h3, 1'b0) ##0 execOperands == {$past(codeData, 1), $past(codeData, 2)};
	endproperty
	a_andImmDirect: assert property (p_andImmDirect) else $error("and immediate direct not three");

	property p_orImmDirect;
		s_start(8'h43) |=> (codeAddr == $past(codeAddr) + 16'h0001) ##2 s_done(4'h3, 1'b0);
	endproperty
	a_orImmDirect: assert property (p_orImmDirect) else $error("or immediate direct wrong");

	property p_incDirect;
		s_start(8'h05) |-> ##2 s_done(4'h2, 1'b0);
	endproperty
	a_incDirect: assert property (p_incDirect) else $error("increment direct not two clocks");

	property p_addWithCarryReg;
		s_start(8'h3B) |=> s_done(4'h1, 1'b0);
	endproperty
	a_addWithCarryReg: assert property (p_addWithCarryReg) else $error("add with carry register not one");

	property p_carryJump;
		s_start(8'h40) |-> ##2 s_done(4'h2, 1'b0) or ##3 s_done(4'h3, 1'b1);
	endproperty
	a_carryJump: assert property (p_carryJump) else $error("carry jump timing wrong");

	property p_compareDirect;
		s_start(8'hB5) |-> ##4 s_done(4'h4, 1'b0) or ##5 s_done(4'h5, 1'b1);
	endproperty
	a_compareDirect: assert property (p_compareDirect) else $error("compare direct jump timing wrong");

	property p_extMove;
		s_start(8'hE0) or s_start(8'hF0) |-> ##3 s_done(4'h3, 1'b0);
	endproperty
	a_extMove: assert property (p_extMove) else $error("external move not three clocks");

	property p_redirect;
		redirect |=> codeAddr == $past(branchTarget) && opStart;
	endproperty
	a_redirect: assert property (p_redirect) else $error("jump did not reach target");

	property p_absCall;
		s_start(8'h11) |-> ##3 s_done(4'h3, 1'b0);
	endproperty
	a_absCall: assert property (p_absCall) else $error("absolute call not three clocks");

	property p_longJump;
		s_start(8'h02) |-> ##4 s_done(4'h4, 1'b0);
	endproperty
	a_longJump: assert property (p_longJump) else $error("long jump not four clocks");

	property p_return;
		s_start(8'h22) |-> ##5 s_done(4'h5, 1'b0);
	endproperty
	a_return: assert property (p_return) else $error("return not five clocks");

	property p_bitJump;
		s_start(8'h20) |-> ##3 s_done(4'h3, 1'b0) or ##4 s_done(4'h4, 1'b1);
	endproperty
	a_bitJump: assert property (p_bitJump) else $error("bit jump timing wrong");

	// Extra execution clocks fetch nothing, so the address must hold
	property p_holdAddr;
		stateQ == mcu_timing_pkg::ST_EXEC && !fetching && !redirect |=> $stable(codeAddr);
	endproperty
	a_holdAddr: assert property (p_holdAddr) else $error("fetch address moved without a fetch");

	property p_fetchStep;
		fetching && !redirect |=> codeAddr == $past(codeAddr) + 16'h0001;
	endproperty
	a_fetchStep: assert property (p_fetchStep) else $error("operand fetch did not advance");

endmodule : mcu_core_instruction_timing

`default_nettype wire

// file: tb/code_mem_model.sv
/*
 * Program memory model: 256-byte image with asynchronous read.
 * Assumes the bench loads the image while the core is held in reset.
 */
`timescale 1ns/100ps
`default_nettype none

module code_mem_model (
	input wire logic [15:0] codeAddr,
	output logic [7:0] codeData
);
	logic [7:0] image [0:255];

	// Unmapped space floats: a changing pattern, never a stale byte
	always_comb begin
		if (codeAddr[15:8] == 8'h00) begin
			codeData = image[codeAddr[7:0]];
		end else begin
			codeData = ~codeAddr[7:0];
		end
	end
endmodule : code_mem_model

`default_nettype wire

// file: tb/mcu_core_instruction_timing_tb.sv
/*
 * Self-checking bench of the instruction sequencer: loads short programs,
 * counts clocks to each retire and checks the retire record and next fetch.
 * Assumes the program memory model answers in the same cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module mcu_core_instruction_timing_tb;
	typedef struct packed {
		logic [7:0] op;
		logic [1:0] len;
		logic [3:0] clk;
		logic cond;
		logic jmp;
	} step_t;

	localparam logic [15:0] TARGET = 16'h0080;

	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic branchTaken = 1'b0;
	logic [15:0] branchTarget = TARGET;
	logic [15:0] codeAddr;
	logic [7:0] codeData;
	logic [7:0] execOpcode;
	logic [15:0] execOperands;
	logic [3:0] execCycle;
	logic instrDone;
	logic [7:0] doneOpcode;
	logic [3:0] doneCycles;
	logic doneTaken;
	int failures = 0;
	int checksDone = 0;
	step_t prog[$];

	always #12.5 sys_clk = ~sys_clk;

	mcu_core_instruction_timing uut (
		.sys_clk(sys_clk),
		.rst(rst),
		.codeAddr(codeAddr),
		.codeData(codeData),
		.branchTaken(branchTaken),
		.branchTarget(branchTarget),
		.execOpcode(execOpcode),
		.execOperands(execOperands),
		.execCycle(execCycle),
		.instrDone(instrDone),
		.doneOpcode(doneOpcode),
		.doneCycles(doneCycles),
		.doneTaken(doneTaken)
	);

	code_mem_model codeMem (
		.codeAddr(codeAddr),
		.codeData(codeData)
	);

	task automatic end_sim;
		if (failures == 0 && checksDone > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checksDone++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic add(input logic [7:0] op, input logic [1:0] len, input logic [3:0] clk,
		input logic cond, input logic jmp);
		prog.push_back({op, len, clk, cond, jmp});
	endtask : add

	// Register, direct, indirect and immediate forms of one operator
	task automatic group(input logic [7:0] base);
		add(base + 8'h08, 2'h1, 4'h1, 1'b0, 1'b0);
		add(base + 8'h05, 2'h2, 4'h2, 1'b0, 1'b0);
		add(base + 8'h06, 2'h1, 4'h2, 1'b0, 1'b0);
		add(base + 8'h04, 2'h2, 4'h2, 1'b0, 1'b0);
	endtask : group

	// Runs the queued program from address 0 after a fresh reset
	task automatic run_prog(input logic tk);
		logic [15:0] pc;
		logic [15:0] nxt;
		logic [3:0] expC;
		logic took;
		logic [15:0] expO;
		rst = 1'b1;
		branchTaken = tk;
		for (int a = 0; a < 256; a++) begin
			codeMem.image[a] = 8'h00;
		end
		pc = 16'h0000;
		foreach (prog[i]) begin
			codeMem.image[pc[7:0]] = prog[i].op;
			codeMem.image[pc[7:0] + 8'h01] = 8'h5A;
			if (prog[i].len == 2'h3) begin
				codeMem.image[pc[7:0] + 8'h02] = 8'hA5;
			end
			pc = (prog[i].jmp | (prog[i].cond & tk)) ? TARGET : pc + 16'(prog[i].len);
		end
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		pc = 16'h0000;
		foreach (prog[i]) begin
			took = prog[i].cond & tk;
			expO = (prog[i].len == 2'h3) ? 16'hA55A : ((prog[i].len == 2'h2) ? 16'h005A : 16'h0000);
			expC = prog[i].clk + 4'(took);
			nxt = (prog[i].jmp | took) ? TARGET : pc + 16'(prog[i].len);
			for (int n = 1; n <= int'(expC); n++) begin
				@(negedge sys_clk);
				if (n < int'(expC)) begin
					chk(16'(instrDone), 16'h0000, "early retire");
					chk(16'(execCycle), 16'(n), "clock count");
					chk(16'(execOpcode), 16'(prog[i].op), "opcode in flight");
				end else begin
					chk(16'(instrDone), 16'h0001, "retire");
					chk(16'(doneOpcode), 16'(prog[i].op), "retired opcode");
					chk(16'(doneCycles), 16'(expC), "retired clocks");
					chk(16'(doneTaken), 16'(took), "taken flag");
					chk(codeAddr, nxt, "next fetch");
					chk(execOperands, expO, "operand bytes");
				end
			end
			pc = nxt;
		end
		prog.delete();
	endtask : run_prog

	task automatic arith_forms;
		group(8'h20);
		group(8'h30);
		add(8'h3B, 2'h1, 4'h1, 1'b0, 1'b0);
		group(8'h90);
		run_prog(1'b0);
	endtask : arith_forms

	// Branch decision held high: plain opcodes must ignore it
	task automatic logic_forms;
		group(8'h50);
		add(8'h52, 2'h2, 4'h2, 1'b0, 1'b0);
		add(8'h53, 2'h3, 4'h3, 1'b0, 1'b0);
		group(8'h40);
		add(8'h42, 2'h2, 4'h2, 1'b0, 1'b0);
		add(8'h43, 2'h3, 4'h3, 1'b0, 1'b0);
		group(8'h60);
		add(8'h6A, 2'h1, 4'h1, 1'b0, 1'b0);
		add(8'h62, 2'h2, 4'h2, 1'b0, 1'b0);
		add(8'h63, 2'h3, 4'h3, 1'b0, 1'b0);
		run_prog(1'b1);
	endtask : logic_forms

	task automatic step_forms;
		add(8'h04, 2'h1, 4'h1, 1'b0, 1'b0);
		add(8'h08, 2'h1, 4'h1, 1'b0, 1'b0);
		add(8'h05, 2'h2, 4'h2, 1'b0, 1'b0);
		add(8'h15, 2'h2, 4'h2, 1'b0, 1'b0);
		add(8'h16, 2'h1, 4'h2, 1'b0, 1'b0);
		add(8'hA3, 2'h1, 4'h1, 1'b0, 1'b0);
		add(8'hD4, 2'h1, 4'h1, 1'b0, 1'b0);
		add(8'hA4, 2'h1, 4'h4, 1'b0, 1'b0);
		add(8'h84, 2'h1, 4'h8, 1'b0, 1'b0);
		add(8'hE0, 2'h1, 4'h3, 1'b0, 1'b0);
		add(8'hF0, 2'h1, 4'h3, 1'b0, 1'b0);
		run_prog(1'b0);
	endtask : step_forms

	task automatic branch_forms;
		add(8'h40, 2'h2, 4'h2, 1'b1, 1'b0);
		add(8'hB5, 2'h3, 4'h4, 1'b1, 1'b0);
		add(8'hD8, 2'h2, 4'h2, 1'b1, 1'b0);
		add(8'h20, 2'h3, 4'h3, 1'b1, 1'b0);
		add(8'hB4, 2'h3, 4'h3, 1'b1, 1'b0);
		add(8'h80, 2'h2, 4'h3, 1'b0, 1'b1);
		run_prog(1'b0);
		add(8'h40, 2'h2, 4'h2, 1'b1, 1'b0);
		run_prog(1'b1);
		add(8'hB5, 2'h3, 4'h4, 1'b1, 1'b0);
		run_prog(1'b1);
	endtask : branch_forms

	// One redirect per run: every jump lands on the same fixed target
	task automatic jump_forms;
		add(8'h11, 2'h2, 4'h3, 1'b0, 1'b1);
		run_prog(1'b0);
		add(8'h02, 2'h3, 4'h4, 1'b0, 1'b1);
		run_prog(1'b0);
		add(8'h22, 2'h1, 4'h5, 1'b0, 1'b1);
		run_prog(1'b1);
		add(8'h20, 2'h3, 4'h3, 1'b1, 1'b0);
		run_prog(1'b1);
	endtask : jump_forms

	initial begin
		// First run adds two more reset clocks, ten in all
		repeat (8) @(negedge sys_clk);
		arith_forms();
		logic_forms();
		step_forms();
		branch_forms();
		jump_forms();
		end_sim();
	end

	// Whole run is about 160 clocks; this leaves ample margin
	initial begin
		repeat (5000) @(posedge sys_clk);
		failures++;
		end_sim();
	end
endmodule : mcu_core_instruction_timing_tb

`default_nettype wire
